// ---- common/hcsr_cfg.svh ----
`ifndef HCSR_CFG_SVH
`define HCSR_CFG_SVH

// Register byte offsets
`define HCSR_OFS_CMD      8'h00
`define HCSR_OFS_STS      8'h04
`define HCSR_OFS_CFG      8'h08
`define HCSR_OFS_CAP      8'h0c
`define HCSR_OFS_IRQ_STS  8'h10
`define HCSR_OFS_IRQ_MASK 8'h14
`define HCSR_OFS_AUX      8'h18
`define HCSR_OFS_VF_SLOT  8'h1c

// Command register fields
`define HCSR_CMD_RUN_STOP 0
`define HCSR_CMD_LRESET   7
`define HCSR_CMD_SAVE     8
`define HCSR_CMD_RESTORE  9

// Status register fields
`define HCSR_STS_HALTED   0
`define HCSR_STS_SAVE     8
`define HCSR_STS_RESTORE  9

// Config, capability and interrupt fields
`define HCSR_CFG_FLUSH    0
`define HCSR_CAP_LRESET   0
`define HCSR_IRQ_SAVE     0
`define HCSR_IRQ_RESTORE  1
`define HCSR_IRQ_LRESET   2
`define HCSR_IRQ_W        3

// Light reset supported by this build
`define HCSR_LRESET_IMPL  1'b1

// Reset values
`define HCSR_RST_AUX      32'h0000_0000
`define HCSR_RST_VF_SLOT  8'hff
`define HCSR_VF_SLOT_W    8

// Operation lengths in aclk cycles
`define HCSR_SAVE_CYC     8'd16
`define HCSR_FLUSH_CYC    8'd32
`define HCSR_RESTORE_CYC  8'd16
`define HCSR_LRESET_CYC   8'd8

// Bus responses
`define HCSR_RESP_OKAY    2'h0
`define HCSR_RESP_SLVERR  2'h2

`endif

// ---- common/hcsr_pkg.sv ----
package hcsr_pkg;

  typedef enum logic [2:0] {
    eng_idle,
    eng_save,
    eng_flush,
    eng_restore,
    eng_lreset
  } hcsr_eng_state_t;

  typedef struct packed {
    logic save;
    logic restore;
    logic lreset;
    logic flush_en;
  } hcsr_eng_req_t;

  typedef struct packed {
    logic save_busy;
    logic restore_busy;
    logic lreset_busy;
    logic flush_active;
    logic save_done;
    logic restore_done;
    logic lreset_done;
  } hcsr_eng_sts_t;

endpackage

// ---- design/hcsr_state_engine.sv ----
`timescale 1ns/1ps
`include "hcsr_cfg.svh"

module hcsr_state_engine (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Start requests as one-cycle pulses, with the flush enable as a level
  input  wire hcsr_pkg::hcsr_eng_req_t req,
  // Progress and completion
  output hcsr_pkg::hcsr_eng_sts_t      sts
);

  hcsr_pkg::hcsr_eng_state_t state_r;
  hcsr_pkg::hcsr_eng_state_t state_nxt;
  logic [7:0]                cnt_r;
  logic [7:0]                cnt_nxt;
  logic                      flush_r;
  logic                      flush_nxt;
  hcsr_pkg::hcsr_eng_sts_t   sts_r;
  hcsr_pkg::hcsr_eng_sts_t   sts_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    flush_nxt = flush_r;
    sts_nxt   = '0;
    case (state_r)
      hcsr_pkg::eng_idle: begin
        // One operation at a time; a light reset outranks save and restore
        if (req.lreset) begin
          state_nxt = hcsr_pkg::eng_lreset;
          cnt_nxt   = `HCSR_LRESET_CYC;
        end else if (req.save) begin
          state_nxt = hcsr_pkg::eng_save;
          cnt_nxt   = `HCSR_SAVE_CYC;
          flush_nxt = req.flush_en;
        end else if (req.restore) begin
          state_nxt = hcsr_pkg::eng_restore;
          cnt_nxt   = `HCSR_RESTORE_CYC;
        end
      end
      hcsr_pkg::eng_save: begin
        if (cnt_r == 8'h01) begin
          if (flush_r) begin
            state_nxt = hcsr_pkg::eng_flush;
            cnt_nxt   = `HCSR_FLUSH_CYC;
          end else begin
            state_nxt        = hcsr_pkg::eng_idle;
            sts_nxt.save_done = 1'b1;
          end
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      hcsr_pkg::eng_flush: begin
        if (cnt_r == 8'h01) begin
          state_nxt         = hcsr_pkg::eng_idle;
          sts_nxt.save_done = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      hcsr_pkg::eng_restore: begin
        if (cnt_r == 8'h01) begin
          state_nxt            = hcsr_pkg::eng_idle;
          sts_nxt.restore_done = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      hcsr_pkg::eng_lreset: begin
        if (cnt_r == 8'h01) begin
          state_nxt           = hcsr_pkg::eng_idle;
          sts_nxt.lreset_done = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      default: begin
        state_nxt = hcsr_pkg::eng_idle;
      end
    endcase
    sts_nxt.save_busy    = (state_nxt == hcsr_pkg::eng_save) ||
                           (state_nxt == hcsr_pkg::eng_flush);
    sts_nxt.flush_active = (state_nxt == hcsr_pkg::eng_flush);
    sts_nxt.restore_busy = (state_nxt == hcsr_pkg::eng_restore);
    sts_nxt.lreset_busy  = (state_nxt == hcsr_pkg::eng_lreset);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= hcsr_pkg::eng_idle;
      cnt_r   <= 8'h00;
      flush_r <= 1'b0;
      sts_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      flush_r <= flush_nxt;
      sts_r   <= sts_nxt;
    end
  end

  assign sts = sts_r;

endmodule // hcsr_state_engine

// ---- design/hcsr_top.sv ----
`timescale 1ns/1ps
`include "hcsr_cfg.svh"

// Function
// - Light reset leaves every auxiliary-well register at its prior value.
// - Light reset disables this function's slots, stops its run bit and clears the context flush enable.
// - Without light reset support, the light-reset flag always reads zero.
// - Light-reset flag reads one while in progress, zero when done.
// - Light-reset flag works only when light-reset capability reads one.
// - Save trigger is command bit 8, resets zero; saves state when halted.
// - Save with context flush enabled also writes out cached contexts.
// - No save when trigger written zero or controller not halted.
// - Save trigger bit always reads zero.
// - Restore trigger is command bit 9, resets zero; restores when halted.
// - No restore when written zero, running, or not halted.
// - Restore trigger bit always reads zero.
// - Save and restore completion shown by their in-progress status flags.

module hcsr_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Controller state
  output logic             run_stop,
  output logic             controller_halted_status,
  output logic [7:0]       vf_slot_en,
  output logic             ctx_flush_active,
  // Interrupt
  output logic             irq
);

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `HCSR_OFS_CMD) || (a == `HCSR_OFS_STS) ||
             (a == `HCSR_OFS_CFG) || (a == `HCSR_OFS_CAP) ||
             (a == `HCSR_OFS_IRQ_STS) || (a == `HCSR_OFS_IRQ_MASK) ||
             (a == `HCSR_OFS_AUX) || (a == `HCSR_OFS_VF_SLOT);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = d[i*8 +: 8];
      end
    end
  endfunction

  // Write channel state
  logic                        aw_hold_r, aw_hold_nxt;
  logic [7:0]                  aw_addr_r, aw_addr_nxt;
  logic                        w_hold_r, w_hold_nxt;
  logic [31:0]                 w_data_r, w_data_nxt;
  logic [3:0]                  w_strb_r, w_strb_nxt;
  logic                        bvalid_r, bvalid_nxt;
  logic [1:0]                  bresp_r, bresp_nxt;
  // Read channel state
  logic                        rvalid_r, rvalid_nxt;
  logic [31:0]                 rdata_r, rdata_nxt;
  logic [1:0]                  rresp_r, rresp_nxt;
  // Registers
  logic                        run_stop_r, run_stop_nxt;
  logic                        halted_r, halted_nxt;
  logic                        flush_en_r, flush_en_nxt;
  logic [`HCSR_IRQ_W-1:0]      irq_sts_r, irq_sts_nxt;
  logic [`HCSR_IRQ_W-1:0]      irq_mask_r, irq_mask_nxt;
  logic [31:0]                 aux_r, aux_nxt;
  logic [`HCSR_VF_SLOT_W-1:0]  slot_r, slot_nxt;
  logic                        irq_r, irq_nxt;
  // Engine
  hcsr_pkg::hcsr_eng_req_t     eng_req;
  hcsr_pkg::hcsr_eng_sts_t     eng_sts;
  logic                        eng_idle;
  logic                        wr_fire;
  logic                        rd_fire;
  logic [31:0]                 cmd_rd;
  logic [31:0]                 sts_rd;
  logic [31:0]                 wmerged;
  logic [`HCSR_IRQ_W-1:0]      irq_events;

  hcsr_state_engine i_hcsr_state_engine (
    .aclk    (aclk),
    .aresetn (aresetn),
    .req     (eng_req),
    .sts     (eng_sts)
  );

  assign eng_idle = !(eng_sts.save_busy || eng_sts.restore_busy || eng_sts.lreset_busy);
  assign wr_fire  = aw_hold_r && w_hold_r && !bvalid_r;
  assign rd_fire  = s_axi_arvalid && !rvalid_r;

  // Readback views; save and restore trigger bits are not stored so they always read zero
  always_comb begin
    cmd_rd                       = 32'h0000_0000;
    cmd_rd[`HCSR_CMD_RUN_STOP]   = run_stop_r;
    cmd_rd[`HCSR_CMD_LRESET]     = `HCSR_LRESET_IMPL & eng_sts.lreset_busy;
    cmd_rd[`HCSR_CMD_SAVE]       = 1'b0;
    cmd_rd[`HCSR_CMD_RESTORE]    = 1'b0;
    sts_rd                       = 32'h0000_0000;
    sts_rd[`HCSR_STS_HALTED]     = halted_r;
    sts_rd[`HCSR_STS_SAVE]       = eng_sts.save_busy;
    sts_rd[`HCSR_STS_RESTORE]    = eng_sts.restore_busy;
  end

  assign irq_events = {eng_sts.lreset_done, eng_sts.restore_done, eng_sts.save_done};

  // Bus channels
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_hold_nxt  = w_hold_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (s_axi_awvalid && !aw_hold_r) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_r) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (wr_fire) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = mapped(aw_addr_r) ? `HCSR_RESP_OKAY : `HCSR_RESP_SLVERR;
    end
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `HCSR_RESP_OKAY;
      if (s_axi_araddr == `HCSR_OFS_CMD) begin
        rdata_nxt = cmd_rd;
      end else if (s_axi_araddr == `HCSR_OFS_STS) begin
        rdata_nxt = sts_rd;
      end else if (s_axi_araddr == `HCSR_OFS_CFG) begin
        rdata_nxt = {31'h0000_0000, flush_en_r};
      end else if (s_axi_araddr == `HCSR_OFS_CAP) begin
        rdata_nxt = {31'h0000_0000, `HCSR_LRESET_IMPL};
      end else if (s_axi_araddr == `HCSR_OFS_IRQ_STS) begin
        rdata_nxt = {29'h0000_0000, irq_sts_r};
      end else if (s_axi_araddr == `HCSR_OFS_IRQ_MASK) begin
        rdata_nxt = {29'h0000_0000, irq_mask_r};
      end else if (s_axi_araddr == `HCSR_OFS_AUX) begin
        rdata_nxt = aux_r;
      end else if (s_axi_araddr == `HCSR_OFS_VF_SLOT) begin
        rdata_nxt = {24'h00_0000, slot_r};
      end else begin
        rdata_nxt = 32'h0000_0000;
        rresp_nxt = `HCSR_RESP_SLVERR;
      end
    end
  end

  // Register writes and command triggers
  always_comb begin
    run_stop_nxt = run_stop_r;
    flush_en_nxt = flush_en_r;
    irq_mask_nxt = irq_mask_r;
    aux_nxt      = aux_r;
    slot_nxt     = slot_r;
    eng_req      = '0;
    eng_req.flush_en = flush_en_r;
    wmerged      = 32'h0000_0000;
    if (wr_fire) begin
      if (aw_addr_r == `HCSR_OFS_CMD) begin
        wmerged = merge(cmd_rd, w_data_r, w_strb_r);
        // Run/stop is frozen while a light reset is under way
        if (!eng_sts.lreset_busy) begin
          run_stop_nxt = wmerged[`HCSR_CMD_RUN_STOP];
        end
        // Overlapping requests are refused while the engine is busy
        if (eng_idle) begin
          eng_req.lreset  = wmerged[`HCSR_CMD_LRESET] & `HCSR_LRESET_IMPL;
          eng_req.save    = wmerged[`HCSR_CMD_SAVE] & halted_r;
          eng_req.restore = wmerged[`HCSR_CMD_RESTORE] & halted_r &
                            !run_stop_r;
        end
      end else if (aw_addr_r == `HCSR_OFS_CFG) begin
        wmerged      = merge({31'h0000_0000, flush_en_r}, w_data_r, w_strb_r);
        flush_en_nxt = wmerged[`HCSR_CFG_FLUSH];
      end else if (aw_addr_r == `HCSR_OFS_IRQ_MASK) begin
        wmerged      = merge({29'h0000_0000, irq_mask_r}, w_data_r, w_strb_r);
        irq_mask_nxt = wmerged[`HCSR_IRQ_W-1:0];
      end else if (aw_addr_r == `HCSR_OFS_AUX) begin
        aux_nxt = merge(aux_r, w_data_r, w_strb_r);
      end else if (aw_addr_r == `HCSR_OFS_VF_SLOT) begin
        wmerged  = merge({24'h00_0000, slot_r}, w_data_r, w_strb_r);
        slot_nxt = wmerged[`HCSR_VF_SLOT_W-1:0];
      end
    end
    // Light reset clears this function's run bit, slots and flush enable; aux is kept
    if (eng_req.lreset) begin
      run_stop_nxt = 1'b0;
      slot_nxt     = '0;
      flush_en_nxt = 1'b0;
      aux_nxt      = aux_r;
    end
    halted_nxt = !run_stop_r;
  end

  // Interrupt status; a read clears, an event in the same cycle still sets
  always_comb begin
    irq_sts_nxt = irq_sts_r;
    if (rd_fire && (s_axi_araddr == `HCSR_OFS_IRQ_STS)) begin
      irq_sts_nxt = '0;
    end
    irq_sts_nxt = irq_sts_nxt | irq_events;
    irq_nxt     = |(irq_sts_nxt & irq_mask_nxt);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r  <= 1'b0;
      aw_addr_r  <= 8'h00;
      w_hold_r   <= 1'b0;
      w_data_r   <= 32'h0000_0000;
      w_strb_r   <= 4'h0;
      bvalid_r   <= 1'b0;
      bresp_r    <= `HCSR_RESP_OKAY;
      rvalid_r   <= 1'b0;
      rdata_r    <= 32'h0000_0000;
      rresp_r    <= `HCSR_RESP_OKAY;
      run_stop_r <= 1'b0;
      halted_r   <= 1'b1;
      flush_en_r <= 1'b0;
      irq_sts_r  <= '0;
      irq_mask_r <= '0;
      aux_r      <= `HCSR_RST_AUX;
      slot_r     <= `HCSR_RST_VF_SLOT;
      irq_r      <= 1'b0;
    end else begin
      aw_hold_r  <= aw_hold_nxt;
      aw_addr_r  <= aw_addr_nxt;
      w_hold_r   <= w_hold_nxt;
      w_data_r   <= w_data_nxt;
      w_strb_r   <= w_strb_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      rvalid_r   <= rvalid_nxt;
      rdata_r    <= rdata_nxt;
      rresp_r    <= rresp_nxt;
      run_stop_r <= run_stop_nxt;
      halted_r   <= halted_nxt;
      flush_en_r <= flush_en_nxt;
      irq_sts_r  <= irq_sts_nxt;
      irq_mask_r <= irq_mask_nxt;
      aux_r      <= aux_nxt;
      slot_r     <= slot_nxt;
      irq_r      <= irq_nxt;
    end
  end

  assign s_axi_awready            = !aw_hold_r;
  assign s_axi_wready             = !w_hold_r;
  assign s_axi_bvalid             = bvalid_r;
  assign s_axi_bresp              = bresp_r;
  assign s_axi_arready            = !rvalid_r;
  assign s_axi_rvalid             = rvalid_r;
  assign s_axi_rdata              = rdata_r;
  assign s_axi_rresp              = rresp_r;
  assign run_stop                 = run_stop_r;
  assign controller_halted_status = halted_r;
  assign vf_slot_en               = slot_r;
  assign ctx_flush_active         = eng_sts.flush_active;
  assign irq                      = irq_r;

endmodule // hcsr_top

// ---- testbench/hcsr_top_chk.sv ----
`timescale 1ns/1ps
`include "hcsr_cfg.svh"

module hcsr_top_chk (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read channels
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Controller state
  input wire logic        run_stop,
  input wire logic        controller_halted_status,
  input wire logic        ctx_flush_active
);
  logic [7:0] ar_addr_r;
  logic [7:0] ar_addr_nxt;
  logic [7:0] flush_cnt_r;
  logic [7:0] flush_cnt_nxt;

  // Remembers the read address so the answer can be judged by register
  always_comb begin
    ar_addr_nxt   = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ar_addr_r;
    flush_cnt_nxt = ctx_flush_active ? flush_cnt_r + 8'h01 : 8'h00;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_addr_r   <= 8'h00;
      flush_cnt_r <= 8'h00;
    end else begin
      ar_addr_r   <= ar_addr_nxt;
      flush_cnt_r <= flush_cnt_nxt;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped early");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  chk_w_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_bvalid |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  chk_save_rd_zero: assert property (s_axi_rvalid && ar_addr_r == `HCSR_OFS_CMD |-> !s_axi_rdata[8])
    else $error("save trigger read as one");
  chk_rest_rd_zero: assert property (s_axi_rvalid && ar_addr_r == `HCSR_OFS_CMD |-> !s_axi_rdata[9])
    else $error("restore trigger read as one");
  chk_flush_len: assert property ($fell(ctx_flush_active) |-> flush_cnt_r == `HCSR_FLUSH_CYC)
    else $error("flush phase length wrong");
  chk_unmapped_rd: assert property (s_axi_rvalid && ar_addr_r > 8'h1c |->
    s_axi_rresp == `HCSR_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_halt_follow: assert property (1'b1 |-> controller_halted_status == !$past(run_stop))
    else $error("halted does not follow run bit");
endmodule // hcsr_top_chk

bind hcsr_top hcsr_top_chk i_hcsr_top_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .run_stop(run_stop), .controller_halted_status(controller_halted_status),
  .ctx_flush_active(ctx_flush_active)
);

// ---- testbench/hcsr_top_test.sv ----
`timescale 1ns/1ps
`include "hcsr_cfg.svh"

module hcsr_top_test;
  logic        aclk, aresetn, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
  logic        run_stop, halted, flush, irq;
  logic [7:0]  awa, ara, vf_slot_en, vf_v;
  logic [31:0] wd, rd_d, aux_v;
  logic [3:0]  ws;
  logic [1:0]  bresp, rresp;
  logic [34:0] exp_q[$];
  int          error_cnt = 0;
  int          comparisons = 0;
  int          n;

  hcsr_top i_hcsr_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .run_stop(run_stop),
    .controller_halted_status(halted), .vf_slot_en(vf_slot_en), .ctx_flush_active(flush),
    .irq(irq));

  task automatic wrap_up;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Bit 34 of a note says whether the data field matters
  task automatic cmp(input logic [33:0] got, input logic [34:0] e);
    logic [33:0] m;
    m = e[34] ? 34'h3_ffff_ffff : 34'h3_0000_0000;
    comparisons++;
    if (((got ^ e[33:0]) & m) !== 34'h0) begin
      error_cnt++;
      $display("wrong value at %0t got %h exp %h", $time, got, e[33:0]);
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    cmp({2'h0, got}, {3'h4, e});
  endtask

  // Handshakes are judged at the falling edge, where nothing is still moving
  always @(negedge aclk) begin
    if (aresetn && ((bv && br) || (rv && rr))) begin
      if (exp_q.size() == 0) cmp({bresp, rd_d}, 35'h7_ffff_ffff);
      else cmp(bv && br ? {bresp, 32'h0} : {rresp, rd_d}, exp_q.pop_front());
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    bit hw, hd, hb, hv;
    exp_q.push_back({1'b0, r, 32'h0});
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    // A late bready lets the response wait on the master now and then
    br <= 1'($urandom);
    hb = 0;
    for (int i = 0; i < 100 && !hb; i++) begin
      @(negedge aclk);
      hw = awv && awr;
      hd = wv && wr_rdy;
      hb = bv && br;
      hv = bv;
      @(posedge aclk);
      if (hw) awv <= 1'b0;
      if (hd) wv <= 1'b0;
      if (hb) br <= 1'b0;
      else if (hv) br <= 1'b1;
    end
    if (!hb) begin
      error_cnt++;
      wrap_up;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    bit ha, hb, hv;
    exp_q.push_back({1'b1, r, e});
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'($urandom);
    hb = 0;
    for (int i = 0; i < 100 && !hb; i++) begin
      @(negedge aclk);
      ha = arv && arr;
      hb = rv && rr;
      hv = rv;
      @(posedge aclk);
      if (ha) arv <= 1'b0;
      if (hb) rr <= 1'b0;
      else if (hv) rr <= 1'b1;
    end
    if (!hb) begin
      error_cnt++;
      wrap_up;
    end
  endtask

  task automatic wait_irq(input logic lvl);
    for (n = 0; n < 300 && irq !== lvl; n++) @(negedge aclk);
    if (irq !== lvl) begin
      error_cnt++;
      wrap_up;
    end
  endtask

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  initial begin
    {aresetn, awv, wv, br, arv, rr, awa, ara, wd} = '0;
    ws = 4'hf;
    void'($urandom(59990));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values and an unmapped place
    rd(`HCSR_OFS_CMD, 32'h0);
    rd(`HCSR_OFS_STS, 32'h1);
    rd(`HCSR_OFS_CAP, 32'h1);
    rd(`HCSR_OFS_VF_SLOT, 32'hff);
    rd(`HCSR_OFS_IRQ_STS, 32'h0);
    rd(8'h20, 32'h0, `HCSR_RESP_SLVERR);
    wr(8'h20, 32'hff, `HCSR_RESP_SLVERR);
    wr(`HCSR_OFS_IRQ_MASK, 32'h7);
    // Save while halted, then read-clear of the sticky bit
    wr(`HCSR_OFS_CMD, 32'h100);
    rd(`HCSR_OFS_CMD, 32'h0);
    rd(`HCSR_OFS_STS, 32'h101);
    wait_irq(1'b1);
    rd(`HCSR_OFS_STS, 32'h1);
    rd(`HCSR_OFS_IRQ_STS, 32'h1);
    rd(`HCSR_OFS_IRQ_STS, 32'h0);
    wait_irq(1'b0);
    // Save with context flush
    wr(`HCSR_OFS_CFG, 32'h1);
    wr(`HCSR_OFS_CMD, 32'h100);
    for (n = 0; n < 60 && flush !== 1'b1; n++) @(negedge aclk);
    chk({31'h0, flush}, 32'h1);
    wait_irq(1'b1);
    rd(`HCSR_OFS_IRQ_STS, 32'h1);
    wait_irq(1'b0);
    // Triggers refused while running or written zero
    wr(`HCSR_OFS_CMD, 32'h1);
    wr(`HCSR_OFS_CMD, 32'h101);
    wr(`HCSR_OFS_CMD, 32'h201);
    rd(`HCSR_OFS_STS, 32'h0);
    wr(`HCSR_OFS_CMD, 32'h0);
    wr(`HCSR_OFS_CMD, 32'h0);
    rd(`HCSR_OFS_STS, 32'h1);
    rd(`HCSR_OFS_IRQ_STS, 32'h0);
    // Restore while halted
    wr(`HCSR_OFS_CMD, 32'h200);
    rd(`HCSR_OFS_CMD, 32'h0);
    rd(`HCSR_OFS_STS, 32'h201);
    wait_irq(1'b1);
    rd(`HCSR_OFS_IRQ_STS, 32'h2);
    wait_irq(1'b0);
    // Masked event keeps the line low but the bit sticks
    wr(`HCSR_OFS_IRQ_MASK, 32'h0);
    wr(`HCSR_OFS_CMD, 32'h100);
    repeat (60) @(negedge aclk) chk({31'h0, irq}, 32'h0);
    rd(`HCSR_OFS_IRQ_STS, 32'h1);
    wr(`HCSR_OFS_IRQ_MASK, 32'h7);
    // Light reset keeps the retained word and stops this function
    aux_v = $urandom;
    vf_v = 8'($urandom);
    wr(`HCSR_OFS_AUX, aux_v);
    wr(`HCSR_OFS_VF_SLOT, {24'h0, vf_v});
    wr(`HCSR_OFS_CFG, 32'h1);
    wr(`HCSR_OFS_CMD, 32'h1);
    wr(`HCSR_OFS_CMD, 32'h80);
    rd(`HCSR_OFS_CMD, 32'h80);
    wait_irq(1'b1);
    rd(`HCSR_OFS_CMD, 32'h0);
    chk({31'h0, run_stop}, 32'h0);
    chk({24'h0, vf_slot_en}, 32'h0);
    rd(`HCSR_OFS_AUX, aux_v);
    // Byte strobes: only the second byte is overwritten
    ws <= 4'h2;
    wr(`HCSR_OFS_AUX, 32'h0);
    ws <= 4'hf;
    rd(`HCSR_OFS_AUX, aux_v & 32'hffff_00ff);
    rd(`HCSR_OFS_CFG, 32'h0);
    rd(`HCSR_OFS_IRQ_STS, 32'h4);
    repeat (4) @(posedge aclk);
    wrap_up;
  end
endmodule // hcsr_top_test
